// ==== src/dim_sup_pkg.sv ====
/*
 Constants, types and the packet checksum for the contact input supervisor.
 Assumes a single 25 MHz clock; the serial link itself lives outside this block.
*/
package dim_sup_pkg;
   localparam int CHANNELS        = 32;
   localparam int FIFO_DEPTH      = 32;
   localparam int CLOCK_KHZ       = 25000;
   localparam int EXCHANGE_MS     = 5;
   localparam int EXCHANGE_CYCLES = EXCHANGE_MS * CLOCK_KHZ;
   localparam int LINK_MBPS       = 100;
   localparam int STARTUP_FRAMES  = 2;
   localparam logic [3:0] MISS_LIMIT_RST = 4'h3;
   localparam logic [7:0] CRC_POLY  = 8'h07;
   localparam logic [7:0] ERR_NONE    = 8'h00;
   localparam logic [7:0] ERR_CHANNEL = 8'h10;
   localparam logic [7:0] ERR_LATE    = 8'h20;
   localparam logic [7:0] ERR_COMM    = 8'h30;
   localparam logic [7:0] ERR_CORRUPT = 8'h40;
   localparam logic [7:0] ERR_SUPPLY  = 8'h50;
   localparam logic [7:0] ERR_CONFIG  = 8'h60;

   typedef enum logic [4:0] {
      MODE_UNPOWERED = 5'h01,
      MODE_STARTUP   = 5'h02,
      MODE_RUN       = 5'h04,
      MODE_FAULTED   = 5'h08,
      MODE_CONFIG    = 5'h10
   } mode_e;

   typedef struct packed {
      logic [CHANNELS-1:0] inputs;
      logic [CHANNELS-1:0] chan_fail;
      logic [7:0]          seq;
      logic [7:0]          status;
      logic [7:0]          crc;
   } packet_s;

   localparam int PAYLOAD_W = $bits(packet_s) - 8;

   function automatic logic [7:0] crc8(input logic [PAYLOAD_W-1:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = PAYLOAD_W - 1; i >= 0; i--)
      begin
         c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction
endpackage

// ==== src/pkt_fifo.sv ====
/*
 Synchronous first-in first-out buffer with valid and ready on both sides.
 Assumes one clock; clr empties it in one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module pkt_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input  wire logic         clock,
   input  wire logic         nrst,
   input  wire logic         clr,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   wire           push = in_valid && in_ready;
   wire           pop  = out_valid && out_ready;

   assign in_ready  = (cnt_q != (AW+1)'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rd_q];

   always_ff @(posedge clock)
   begin
      if (push)
         mem[wr_q] <= in_data;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || clr)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // pkt_fifo
`default_nettype wire

// ==== src/discrete_input_mode_fault_supervisor.sv ====
/*
 Mode sequencing, acquisition framing and fault latching for the contact input module.
 Assumes a serializer outside that drains tx packets and reports received packet checks,
 and a supply watchdog that removes power when the heartbeat stops or power_cut is high.
*/
`timescale 1ns/1ps
`default_nettype none
module discrete_input_mode_fault_supervisor
   import dim_sup_pkg::*;
#(
   parameter int EXCH_CYCLES = EXCHANGE_CYCLES,
   parameter int START_FRAMES = STARTUP_FRAMES,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic                clock,
   input  wire logic                nrst,
   input  wire logic                power_good,
   input  wire logic [CHANNELS-1:0] contacts,
   input  wire logic [CHANNELS-1:0] line_fault,
   input  wire logic                supply_fault,
   input  wire logic                config_mem_fault,
   input  wire logic                config_request,
   input  wire logic                config_done,
   input  wire logic [3:0]          miss_limit,
   input  wire logic                rx_valid,
   input  wire logic                rx_crc_ok,
   input  wire logic                tx_ready,
   output logic                     tx_valid,
   output packet_s                  tx_packet,
   output mode_e                    mode,
   output logic                     heartbeat,
   output logic [CHANNELS-1:0]      chan_status,
   output logic [7:0]               error_code,
   output logic                     comm_lost,
   output logic                     late_update,
   output logic                     data_corrupt,
   output logic                     power_cut
);
   localparam int FW = $clog2(EXCH_CYCLES);
   localparam int SW = 2 * CHANNELS + 3;

   // Power, supply, config memory, line fault and contact inputs pass two flops; only the second stage is read.
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= {power_good, supply_fault, config_mem_fault, line_fault, contacts};
         sync2_q <= sync1_q;
      end
   end
   wire                pwr_s     = sync2_q[SW-1];
   wire                supply_s  = sync2_q[SW-2];
   wire                cfgmem_s  = sync2_q[SW-3];
   wire [CHANNELS-1:0] linef_s   = sync2_q[2*CHANNELS-1:CHANNELS];
   wire [CHANNELS-1:0] contact_s = sync2_q[CHANNELS-1:0];

   mode_e         mode_q;
   mode_e         mode_d;
   logic [FW-1:0] frame_q;
   logic [3:0]    start_q;
   logic [3:0]    miss_q;
   logic          rx_seen_q;
   logic          pend_q;
   packet_s       snap_q;
   logic [7:0]    seq_q;
   logic          high_q;
   logic          hb_q;
   logic [CHANNELS-1:0] chf_q;
   logic [7:0]    err_q;
   logic          lost_q;
   logic          late_q;
   logic          corrupt_q;
   logic          cut_q;
   logic          txv_q;
   packet_s       txd_q;

   wire unpow   = (mode_q == MODE_UNPOWERED);
   wire active  = (mode_q == MODE_STARTUP) || (mode_q == MODE_RUN);
   wire tick    = active && (frame_q == FW'(EXCH_CYCLES - 1));
   wire rx_good = rx_valid && rx_crc_ok && !unpow;
   wire miss_hit = tick && (mode_q == MODE_RUN) && !rx_seen_q && !rx_good;
   wire [3:0] miss_d = miss_hit ? ((miss_q == 4'hf) ? miss_q : miss_q + 4'h1) : 4'h0;
   wire lost_now = miss_hit && (miss_limit != 4'h0) && (miss_d >= miss_limit);
   wire start_end = tick && (start_q == 4'(START_FRAMES - 1));

   // Acquisition: a frame snapshot waits in pend_q until the buffer takes it.
   wire     fifo_in_ready;
   wire     fifo_out_valid;
   packet_s fifo_out;
   wire     push    = pend_q && fifo_in_ready;
   wire     tx_load = fifo_out_valid && (!txv_q || tx_ready) && active;
   wire     crc_bad = tx_load && (crc8(fifo_out[PAYLOAD_W+7:8]) != fifo_out.crc);
   wire     high_now = crc_bad || supply_s || cfgmem_s;
   packet_s snap_d;
   always_comb
   begin
      snap_d        = '0;
      snap_d.inputs = contact_s;
      snap_d.chan_fail = chf_q | linef_s;
      snap_d.seq    = seq_q;
      snap_d.status = {3'h0, mode_q};
      snap_d.crc    = crc8({contact_s, chf_q | linef_s, seq_q, 3'h0, mode_q});
   end

   pkt_fifo #(.W($bits(packet_s)), .D(DEPTH)) u_fifo (
      .clock     (clock),
      .nrst      (nrst),
      .clr       (!active),
      .in_valid  (pend_q),
      .in_ready  (fifo_in_ready),
      .in_data   (snap_q),
      .out_valid (fifo_out_valid),
      .out_ready (tx_load),
      .out_data  (fifo_out)
   );

   // Error code climbs only towards more severe faults.
   wire [7:0] err_cand = cfgmem_s ? ERR_CONFIG :
                         supply_s ? ERR_SUPPLY :
                         crc_bad  ? ERR_CORRUPT :
                         lost_now ? ERR_COMM :
                         (tick && pend_q) ? ERR_LATE :
                         ((linef_s != '0) && active) ? ERR_CHANNEL : ERR_NONE;

   always_comb
   begin
      mode_d = mode_q;
      case (mode_q)
         MODE_UNPOWERED:
            if (pwr_s)
               mode_d = MODE_STARTUP;
         MODE_STARTUP:
            if (!pwr_s)
               mode_d = MODE_UNPOWERED;
            else if (high_q)
               mode_d = MODE_FAULTED;
            else if (start_end)
               mode_d = MODE_RUN;
         MODE_RUN:
            if (!pwr_s)
               mode_d = MODE_UNPOWERED;
            else if (high_q)
               mode_d = MODE_FAULTED;
            else if (config_request)
               mode_d = MODE_CONFIG;
         MODE_FAULTED:
            if (!pwr_s)
               mode_d = MODE_UNPOWERED;
         MODE_CONFIG:
            if (!pwr_s)
               mode_d = MODE_UNPOWERED;
            else if (config_done)
               mode_d = MODE_STARTUP;
         default:
            mode_d = MODE_UNPOWERED;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
         mode_q <= MODE_UNPOWERED;
      else
         mode_q <= mode_d;
   end

   // Exchange cycle timing and startup length.
   always_ff @(posedge clock)
   begin
      if (!nrst || !active)
      begin
         frame_q <= '0;
         start_q <= '0;
      end
      else
      begin
         frame_q <= tick ? '0 : frame_q + 1'b1;
         if (tick && (mode_q == MODE_STARTUP))
            start_q <= start_q + 4'h1;
      end
   end

   // Acquire at each frame edge with no snapshot still pending in pend_q, then hand over for transmission.
   always_ff @(posedge clock)
   begin
      if (!nrst || !active)
      begin
         pend_q <= 1'b0;
         snap_q <= '0;
         seq_q  <= '0;
      end
      else if (tick && !pend_q)
      begin
         pend_q <= 1'b1;
         snap_q <= snap_d;
      end
      else if (push)
      begin
         pend_q <= 1'b0;
         seq_q  <= seq_q + 8'h01;
      end
   end

   // Startup runs everything except the loss check, which is the restriction.
   always_ff @(posedge clock)
   begin
      if (!nrst || unpow)
      begin
         rx_seen_q <= 1'b0;
         miss_q    <= '0;
      end
      else
      begin
         rx_seen_q <= rx_good || (rx_seen_q && !tick);
         if (tick)
            miss_q <= miss_d;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++)
      begin : g_chan
         always_ff @(posedge clock)
         begin
            if (!nrst || unpow)
               chf_q[ch] <= 1'b0;
            else if (active && linef_s[ch])
               chf_q[ch] <= 1'b1;
         end
      end
   endgenerate

   // Latched faults clear only when power goes away.
   always_ff @(posedge clock)
   begin
      if (!nrst || unpow)
      begin
         err_q     <= ERR_NONE;
         lost_q    <= 1'b0;
         late_q    <= 1'b0;
         corrupt_q <= 1'b0;
         high_q    <= 1'b0;
         cut_q     <= 1'b0;
      end
      else
      begin
         if (err_cand > err_q)
            err_q <= err_cand;
         if (lost_now)
            lost_q <= 1'b1;
         if (tick && pend_q)
            late_q <= 1'b1;
         if (crc_bad)
            corrupt_q <= 1'b1;
         if (high_now)
            high_q <= 1'b1;
         if (high_now || high_q)
            cut_q <= 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || unpow)
         hb_q <= 1'b0;
      else if (tick && !high_q && !high_now)
         hb_q <= !hb_q;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || !active)
      begin
         txv_q <= 1'b0;
         txd_q <= '0;
      end
      else if (tx_load)
      begin
         txv_q <= 1'b1;
         txd_q <= fifo_out;
      end
      else if (tx_ready)
         txv_q <= 1'b0;
   end

   assign tx_valid     = txv_q;
   assign tx_packet    = txd_q;
   assign mode         = mode_q;
   assign heartbeat    = hb_q;
   assign chan_status  = chf_q;
   assign error_code   = err_q;
   assign comm_lost    = lost_q;
   assign late_update  = late_q;
   assign data_corrupt = corrupt_q;
   assign power_cut    = cut_q;
endmodule // discrete_input_mode_fault_supervisor
`default_nettype wire

// ==== verification/dim_sup_asserts.sv ====
/*
 Concurrent checks on the ports of the contact input supervisor.
 Assumes one clock domain and the synchronous active-low reset nrst.
*/
`timescale 1ns/1ps
`default_nettype none
module dim_sup_asserts
   import dim_sup_pkg::*;
#(
   parameter int EXCH_CYCLES = 50
) (
   input wire logic                clock,
   input wire logic                nrst,
   input wire logic                power_good,
   input wire logic                tx_ready,
   input wire logic                tx_valid,
   input wire packet_s             tx_packet,
   input wire mode_e               mode,
   input wire logic                heartbeat,
   input wire logic [CHANNELS-1:0] chan_status,
   input wire logic [7:0]          error_code,
   input wire logic                comm_lost,
   input wire logic                power_cut
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);
   localparam int START_LIMIT = 4 * EXCH_CYCLES;

   logic        hb_q;
   int unsigned quiet_q;

   // Counts run cycles since the heartbeat last moved while the module is healthy.
   always_ff @(posedge clock)
   begin
      hb_q    <= heartbeat;
      quiet_q <= (mode != MODE_RUN || power_cut || comm_lost || heartbeat != hb_q) ? 0 : quiet_q + 1;
   end

   sequence power_gone;
      !power_good [*3];
   endsequence

   sequence held_offer;
      tx_valid && !tx_ready && mode == MODE_RUN ##1 mode == MODE_RUN;
   endsequence

   unpowered_quiet_a:
   assert property (mode == MODE_UNPOWERED && $past(mode) == MODE_UNPOWERED
      |-> !tx_valid && error_code == ERR_NONE) else $error("unpowered module active");
   stay_off_a:
   assert property (mode == MODE_UNPOWERED && !power_good |=> mode == MODE_UNPOWERED)
      else $error("left unpowered without power");
   startup_done_a:
   assert property ($rose(mode == MODE_STARTUP) |-> ##[1:START_LIMIT] mode == MODE_RUN)
      else $error("startup never reached run");
   held_offer_a:
   assert property (held_offer |-> tx_valid && $stable(tx_packet))
      else $error("packet offer dropped or changed");
   power_loss_a:
   assert property (power_gone |=> mode == MODE_UNPOWERED) else $error("power loss ignored");
   code_sticky_a:
   assert property (mode != MODE_UNPOWERED && $past(mode) != MODE_UNPOWERED
      |-> error_code >= $past(error_code) && (chan_status & $past(chan_status)) == $past(chan_status))
      else $error("error report fell back");
   comm_flag_a:
   assert property ($rose(comm_lost) |-> error_code >= ERR_COMM) else $error("loss without code");
   hb_freeze_a:
   assert property (power_cut && $past(power_cut) |-> $stable(heartbeat))
      else $error("heartbeat moved after failure");
   hb_alive_a:
   assert property (quiet_q <= EXCH_CYCLES) else $error("heartbeat stalled");
   fault_cut_a:
   assert property ($rose(power_cut) |-> ##[0:2] mode == MODE_FAULTED) else $error("no faulted mode");
endmodule // dim_sup_asserts
`default_nettype wire

// ==== verification/central_link_model.sv ====
/*
 Behavioural central logic module on the far side of the packet link.
 Assumes the bench drives stall and cmd_en on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module central_link_model
   import dim_sup_pkg::*;
#(
   parameter int GAP = 50
) (
   input  wire logic    clock,
   input  wire logic    nrst,
   input  wire logic    stall,
   input  wire logic    cmd_en,
   input  wire logic    tx_valid,
   input  wire packet_s tx_packet,
   output logic         tx_ready,
   output logic         rx_valid,
   output logic         rx_crc_ok,
   output packet_s      last_pkt,
   output var int       accepted,
   output var int       gap,
   output logic         safe_state
);
   int  tmr_q;
   int  since_q;
   wire trip = since_q >= GAP + GAP / 2;

   assign tx_ready  = ~stall;
   assign rx_valid  = tmr_q == 0;
   // With commands off the packets still arrive but fail their check.
   // Between packets the check line carries a changing pattern.
   assign rx_crc_ok = rx_valid ? cmd_en : tmr_q[0];

   // Output modules hold their safe output register until a response returns.
   always_ff @(posedge clock)
   begin
      if (!nrst || (tx_valid && tx_ready))
         safe_state <= 1'b0;
      else if (trip)
         safe_state <= 1'b1;
   end

   always_ff @(posedge clock)
   begin
      tmr_q   <= (!nrst || tmr_q == GAP / 2 - 1) ? 0 : tmr_q + 1;
      since_q <= since_q + 1;
      if (!nrst)
      begin
         accepted <= 0;
         since_q  <= 0;
      end
      else if (tx_valid && tx_ready)
      begin
         last_pkt <= tx_packet;
         accepted <= accepted + 1;
         gap      <= since_q + 1;
         since_q  <= 0;
      end
   end
endmodule // central_link_model
`default_nettype wire

// ==== verification/discrete_input_mode_fault_supervisor_tb.sv ====
/*
 Self-checking bench for the contact input supervisor and its central link model.
 Assumes the package, FIFO, design, checker and model are compiled ahead of it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
`define WAITC(c, n) begin for (int k = 0; k < (n) && !(c); k++) @(negedge clock); \
   if (!(c)) begin miscompares++; test_done(); end end
module discrete_input_mode_fault_supervisor_tb;
   import dim_sup_pkg::*;
   localparam int EXCH = 50;
   localparam int DEP  = 4;
   logic                clock = 1'b0;
   logic                nrst = 1'b0;
   logic                power_good = 1'b0;
   logic [CHANNELS-1:0] contacts = 32'ha5c3_0f19;
   logic [CHANNELS-1:0] line_fault = '0;
   logic                supply_fault = 1'b0, config_mem_fault = 1'b0;
   logic                config_request = 1'b0, config_done = 1'b0;
   logic                stall = 1'b0, cmd_en = 1'b1, h;
   logic [3:0]          miss_limit = 4'h3;
   logic                tx_ready, rx_valid, rx_crc_ok, tx_valid, heartbeat;
   logic                comm_lost, late_update, data_corrupt, power_cut, safe_state;
   packet_s             tx_packet, last_pkt;
   mode_e               mode;
   logic [CHANNELS-1:0] chan_status;
   logic [7:0]          error_code;
   int                  accepted, gap, n, checked = 0, miscompares = 0;

   always #20 clock = ~clock;

   discrete_input_mode_fault_supervisor #(.EXCH_CYCLES(EXCH), .DEPTH(DEP)) dut (
      .clock, .nrst, .power_good, .contacts, .line_fault, .supply_fault, .config_mem_fault,
      .config_request, .config_done, .miss_limit, .rx_valid, .rx_crc_ok, .tx_ready,
      .tx_valid, .tx_packet, .mode, .heartbeat, .chan_status, .error_code, .comm_lost,
      .late_update, .data_corrupt, .power_cut);

   central_link_model #(.GAP(EXCH)) link (
      .clock, .nrst, .stall, .cmd_en, .tx_valid, .tx_packet, .tx_ready, .rx_valid,
      .rx_crc_ok, .last_pkt, .accepted, .gap, .safe_state);

   function automatic logic [7:0] ref_crc(input logic [79:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 79; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction

   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic power_up;
      power_good = 1'b1;
      `WAITC(mode == MODE_STARTUP, 10)
      `WAITC(mode == MODE_RUN, 4 * EXCH)
   endtask

   initial
   begin
      repeat (4) @(negedge clock);
      nrst = 1'b1;
      repeat (6) @(negedge clock);
      `CHK(mode, MODE_UNPOWERED)
      `CHK({tx_valid, error_code, heartbeat}, 10'h000)
      $display("test unpowered done");
      power_up();
      n = accepted;
      `WAITC(accepted > n + 1, 3 * EXCH)
      `CHK(gap, EXCH)
      `CHK(safe_state, 1'b0)
      `CHK(last_pkt.inputs, contacts)
      `CHK(last_pkt.status, {3'b000, MODE_RUN})
      `CHK(last_pkt.crc, ref_crc(last_pkt[87:8]))
      $display("test packets done");
      line_fault = 32'h8000_0001;
      repeat (6) @(negedge clock);
      line_fault = '0;
      repeat (6) @(negedge clock);
      `CHK(chan_status, 32'h8000_0001)
      `CHK(error_code, ERR_CHANNEL)
      config_request = 1'b1;
      `WAITC(mode == MODE_CONFIG, 10)
      config_request = 1'b0;
      repeat (2 * EXCH) @(negedge clock);
      `CHK(tx_valid, 1'b0)
      `CHK(error_code, ERR_CHANNEL)
      config_done = 1'b1;
      `WAITC(mode == MODE_STARTUP, 10)
      config_done = 1'b0;
      `WAITC(mode == MODE_RUN, 4 * EXCH)
      $display("test channel and config done");
      stall = 1'b1;
      `WAITC(late_update, (DEP + 6) * EXCH)
      `CHK(error_code, ERR_LATE)
      n = accepted;
      stall = 1'b0;
      repeat (DEP + 3) @(negedge clock);
      `CHK(accepted - n >= DEP, 1'b1)
      `CHK(last_pkt.chan_fail, 32'h8000_0001)
      `CHK(data_corrupt, 1'b0)
      $display("test backlog done");
      miss_limit = 4'h0;
      cmd_en = 1'b0;
      repeat (4 * EXCH) @(negedge clock);
      `CHK(comm_lost, 1'b0)
      cmd_en = 1'b1;
      repeat (2 * EXCH) @(negedge clock);
      miss_limit = 4'h3;
      cmd_en = 1'b0;
      repeat (2 * EXCH) @(negedge clock);
      `CHK(comm_lost, 1'b0)
      `WAITC(comm_lost, 3 * EXCH)
      `CHK(error_code, ERR_COMM)
      $display("test comm loss done");
      for (int f = 0; f < 2; f++)
      begin
         power_good = 1'b0;
         repeat (5) @(negedge clock);
         `CHK(mode, MODE_UNPOWERED)
         `CHK({error_code, comm_lost, chan_status}, 41'h0)
         cmd_en = 1'b1;
         power_up();
         {config_mem_fault, supply_fault} = (f == 1) ? 2'b10 : 2'b01;
         `WAITC(mode == MODE_FAULTED, 10)
         `CHK(power_cut, 1'b1)
         h = heartbeat;
         repeat (2 * EXCH) @(negedge clock);
         `CHK(heartbeat, h)
         `CHK(safe_state, 1'b1)
         `CHK(error_code, (f == 1) ? ERR_CONFIG : ERR_SUPPLY)
         {config_mem_fault, supply_fault} = 2'b00;
      end
      power_good = 1'b0;
      repeat (5) @(negedge clock);
      `CHK(mode, MODE_UNPOWERED)
      $display("test faults done");
      test_done();
   end
endmodule // discrete_input_mode_fault_supervisor_tb

bind discrete_input_mode_fault_supervisor dim_sup_asserts #(.EXCH_CYCLES(EXCH_CYCLES)) chk (
   .clock, .nrst, .power_good, .tx_ready, .tx_valid, .tx_packet, .mode, .heartbeat,
   .chan_status, .error_code, .comm_lost, .power_cut);
`default_nettype wire
